// >>> hdl/timer2_split_brg_clockout.sv
`timescale 1ns/1ns

// Function
// - Split mode 1: two 8-bit auto-reload timers
// - Split mode 2: two 8-bit capture timers
// - Split mode 3: capture also zeroes high_count
// - PWM: high pair sets period, low_count compares
// - PWM overflow sets flag, loads low_reload duty
// - PWM reaches clock_out_pin only when enabled
// - tx_clock_select picks Timer 1 or 2
// - rx_clock_select picks receive source independently
// - BRG rollover reloads 16-bit counter from reloads
// - BRG rollover sets overflow_flag, block gates request
// - BRG trigger falling edge sets flag, no reload
// - BRG counts at half clock or pin
// - Split BRG: low pair rate, low flag
// - Clock-out when capture_reload_select 0, enable 1
// - Clock-out counter reloads, toggles per overflow
// - 16-bit clock-out rollovers set overflow_flag, blockable
// - Split clock-out toggles on low_count overflow
// - Low flag interrupts only with its enable
// - overflow_irq_block masks overflow_flag request
// - Mode code 1 0 0 is PWM when split
// - Split: run_high high half, run_low low half
// - flag_view_select remaps control bits five, four
module timer2_split_brg_clockout (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins
  input  wire logic        count_input_pin,
  input  wire logic        trigger_input,
  output logic             clock_out_pin,
  // Serial port and interrupt request
  input  wire logic        timer1_overflow,
  output logic             tx_baud_tick,
  output logic             rx_baud_tick,
  output logic             irq_request
);

  typedef struct packed {
    logic [7:0]  high_count;
    logic [7:0]  low_count;
    logic [7:0]  high_reload;
    logic [7:0]  low_reload;
    logic        overflow_flag;
    logic        external_flag;
    logic        low_overflow_flag;
    logic        low_overflow_irq_enable;
    logic        rx_clock_select;
    logic        tx_clock_select;
    logic        falling_trigger_enable;
    logic        run_high;
    logic        pin_source;
    logic        capture_reload_select;
    logic        split_enable;
    logic        low_fast;
    logic        high_fast;
    logic        run_low;
    logic        clock_out_enable;
    logic        mode_bit0;
    logic        mode_bit2;
    logic        overflow_irq_block;
    logic        flag_view_select;
    logic        half_div;
    logic [2:0]  cnt_sync;
    logic [2:0]  trg_sync;
    logic        cnt_level;
    logic        trg_level;
    logic        clk_level;
    logic        tx_tick;
    logic        rx_tick;
    logic        irq;
    logic        bus_wait;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [2:0]  mode;
  logic        brg;
  logic        clkout;
  logic        pwm;
  logic        cnt_new;
  logic        trg_new;
  logic        pin_fall;
  logic        trg_ev;
  logic        hi_tick;
  logic        lo_tick;
  logic [15:0] cnt16;
  logic        ovf16;
  logic        hovf;
  logic        lovf;
  logic        t2_event;
  logic        wr;
  logic        take;

  // Address match, used by read mux and write decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  // Read mux; flag_view_select remaps bits five and four
  function automatic logic [31:0] read_reg(input state_t s, input logic [4:0] a);
    logic [31:0] r;
    r = timer2_pkg::RD_UNMAP;
    if (hit(a, timer2_pkg::OFF_CONTROL)) begin
      r[timer2_pkg::CON_OVF]   = s.overflow_flag;
      r[timer2_pkg::CON_EXT]   = s.external_flag;
      r[timer2_pkg::CON_VIEW5] = s.flag_view_select ? s.low_overflow_flag
                                                    : s.rx_clock_select;
      r[timer2_pkg::CON_VIEW4] = s.flag_view_select ? s.low_overflow_irq_enable
                                                    : s.tx_clock_select;
      r[timer2_pkg::CON_FALL]  = s.falling_trigger_enable;
      r[timer2_pkg::CON_RUNH]  = s.run_high;
      r[timer2_pkg::CON_PIN]   = s.pin_source;
      r[timer2_pkg::CON_CAPRL] = s.capture_reload_select;
    end else if (hit(a, timer2_pkg::OFF_MODE)) begin
      r[timer2_pkg::MOD_SPLIT] = s.split_enable;
      r[timer2_pkg::MOD_LFAST] = s.low_fast;
      r[timer2_pkg::MOD_HFAST] = s.high_fast;
      r[timer2_pkg::MOD_RUNL]  = s.run_low;
      r[timer2_pkg::MOD_OE]    = s.clock_out_enable;
      r[timer2_pkg::MOD_MS0]   = s.mode_bit0;
    end else if (hit(a, timer2_pkg::OFF_MODE_EXT)) begin
      r[timer2_pkg::MX_BLOCK]  = s.overflow_irq_block;
      r[timer2_pkg::MX_VIEW]   = s.flag_view_select;
      r[timer2_pkg::MX_MS1]    = s.mode_bit2;
    end else if (hit(a, timer2_pkg::OFF_HIGH_COUNT)) begin
      r[7:0] = s.high_count;
    end else if (hit(a, timer2_pkg::OFF_LOW_COUNT)) begin
      r[7:0] = s.low_count;
    end else if (hit(a, timer2_pkg::OFF_HIGH_RELOAD)) begin
      r[7:0] = s.high_reload;
    end else if (hit(a, timer2_pkg::OFF_LOW_RELOAD)) begin
      r[7:0] = s.low_reload;
    end
    read_reg = r;
  endfunction

  // Mode decode; unlisted codes ignore the trigger; 6 and 7 wrap as 16-bit timers, 5 reloads
  assign mode   = {st_q.mode_bit2, st_q.capture_reload_select, st_q.mode_bit0};
  assign pwm    = st_q.split_enable && (mode == timer2_pkg::MODE_PWM);
  assign brg    = !st_q.split_enable && (st_q.rx_clock_select || st_q.tx_clock_select);
  assign clkout = !st_q.capture_reload_select && st_q.clock_out_enable;

  // Filtered pin levels: a change counts once stages two and three agree
  assign cnt_new  = (st_q.cnt_sync[1] == st_q.cnt_sync[2]) ? st_q.cnt_sync[2] : st_q.cnt_level;
  assign trg_new  = (st_q.trg_sync[1] == st_q.trg_sync[2]) ? st_q.trg_sync[2] : st_q.trg_level;
  assign pin_fall = st_q.cnt_level && !cnt_new;
  assign trg_ev   = st_q.trg_level && !trg_new && st_q.falling_trigger_enable;

  // Count enables; the 16-bit BRG never uses the full-rate source
  assign hi_tick = st_q.run_high && (st_q.pin_source ? pin_fall
                   : (st_q.half_div || (st_q.high_fast && !brg)));
  assign lo_tick = st_q.split_enable && st_q.run_low
                   && (st_q.low_fast || st_q.half_div);

  // Overflow events
  assign cnt16    = {st_q.high_count, st_q.low_count};
  assign ovf16    = !st_q.split_enable && hi_tick && (cnt16 == timer2_pkg::MAX16);
  assign hovf     = st_q.split_enable && hi_tick && (st_q.high_count == timer2_pkg::MAX8);
  assign lovf     = !pwm && lo_tick && (st_q.low_count == timer2_pkg::MAX8);
  assign t2_event = st_q.split_enable ? lovf : ovf16;

  // Bus handshake: answer one cycle after the request is seen
  assign take = (avs_read || avs_write) && st_q.bus_wait;
  assign wr   = avs_write && !st_q.bus_wait;

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.half_div = !st_q.half_div;
    st_d.cnt_sync = {st_q.cnt_sync[1:0], count_input_pin};
    st_d.trg_sync = {st_q.trg_sync[1:0], trigger_input};
    st_d.cnt_level = cnt_new;
    st_d.trg_level = trg_new;

    if (!st_q.split_enable) begin
      // 16-bit: reload in BRG, clock-out and modes 0/1/4/5, wrap otherwise
      if (hi_tick) begin
        if (ovf16 && (brg || clkout || !mode[1])) begin
          {st_d.high_count, st_d.low_count} = {st_q.high_reload, st_q.low_reload};
        end else begin
          {st_d.high_count, st_d.low_count} = cnt16 + timer2_pkg::ONE16;
        end
      end
      // Trigger in BRG only flags; modes 1 to 3 reload or capture
      if (trg_ev && !brg) begin
        case (mode)
          timer2_pkg::MODE_AR_TRIG: begin
            {st_d.high_count, st_d.low_count} = {st_q.high_reload, st_q.low_reload};
          end
          timer2_pkg::MODE_CAPTURE: begin
            {st_d.high_reload, st_d.low_reload} = cnt16;
          end
          timer2_pkg::MODE_CAP_ZER: begin
            {st_d.high_reload, st_d.low_reload} = cnt16;
            {st_d.high_count, st_d.low_count} = {timer2_pkg::ZERO8, timer2_pkg::ZERO8};
          end
          default: ;
        endcase
      end
    end else begin
      // Split high half: reload except in the capture modes
      if (hi_tick) begin
        if (hovf && !(mode == timer2_pkg::MODE_CAPTURE || mode == timer2_pkg::MODE_CAP_ZER)) begin
          st_d.high_count = st_q.high_reload;
        end else begin
          st_d.high_count = st_q.high_count + timer2_pkg::ONE8;
        end
      end
      // PWM: duty only moves at period boundary, glitch-free
      if (pwm && hovf) begin
        st_d.low_count = st_q.low_reload;
      end
      // Split low half: 8-bit rate generator
      if (lo_tick && !pwm) begin
        st_d.low_count = lovf ? st_q.low_reload
                              : st_q.low_count + timer2_pkg::ONE8;
      end
      if (trg_ev) begin
        case (mode)
          timer2_pkg::MODE_AR_TRIG: begin
            st_d.high_count = st_q.high_reload;
          end
          timer2_pkg::MODE_CAPTURE: begin
            st_d.high_reload = st_q.high_count;
            st_d.low_reload  = st_q.low_count;
          end
          timer2_pkg::MODE_CAP_ZER: begin
            st_d.high_reload = st_q.high_count;
            st_d.low_reload  = st_q.low_count;
            st_d.high_count  = timer2_pkg::ZERO8;
          end
          default: ;
        endcase
      end
    end

    // Clock output: low when disabled, PWM compare or toggle
    if (!clkout) begin
      st_d.clk_level = 1'b0;
    end else if (pwm) begin
      st_d.clk_level = (st_q.high_count < st_q.low_count);
    end else if (t2_event) begin
      st_d.clk_level = !st_q.clk_level;
    end

    // Baud sources chosen independently for each direction
    st_d.tx_tick = st_q.tx_clock_select ? t2_event : timer1_overflow;
    st_d.rx_tick = st_q.rx_clock_select ? t2_event : timer1_overflow;

    // Register writes; software data wins over counting
    if (wr && hit(avs_address, timer2_pkg::OFF_CONTROL)) begin
      st_d.overflow_flag          = avs_writedata[timer2_pkg::CON_OVF];
      st_d.external_flag          = avs_writedata[timer2_pkg::CON_EXT];
      if (st_q.flag_view_select) begin
        st_d.low_overflow_flag       = avs_writedata[timer2_pkg::CON_VIEW5];
        st_d.low_overflow_irq_enable = avs_writedata[timer2_pkg::CON_VIEW4];
      end else begin
        st_d.rx_clock_select = avs_writedata[timer2_pkg::CON_VIEW5];
        st_d.tx_clock_select = avs_writedata[timer2_pkg::CON_VIEW4];
      end
      st_d.falling_trigger_enable = avs_writedata[timer2_pkg::CON_FALL];
      st_d.run_high               = avs_writedata[timer2_pkg::CON_RUNH];
      st_d.pin_source             = avs_writedata[timer2_pkg::CON_PIN];
      st_d.capture_reload_select  = avs_writedata[timer2_pkg::CON_CAPRL];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_MODE)) begin
      st_d.split_enable     = avs_writedata[timer2_pkg::MOD_SPLIT];
      st_d.low_fast         = avs_writedata[timer2_pkg::MOD_LFAST];
      st_d.high_fast        = avs_writedata[timer2_pkg::MOD_HFAST];
      st_d.run_low          = avs_writedata[timer2_pkg::MOD_RUNL];
      st_d.clock_out_enable = avs_writedata[timer2_pkg::MOD_OE];
      st_d.mode_bit0        = avs_writedata[timer2_pkg::MOD_MS0];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_MODE_EXT)) begin
      st_d.overflow_irq_block = avs_writedata[timer2_pkg::MX_BLOCK];
      st_d.flag_view_select   = avs_writedata[timer2_pkg::MX_VIEW];
      st_d.mode_bit2          = avs_writedata[timer2_pkg::MX_MS1];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_HIGH_COUNT)) begin
      st_d.high_count = avs_writedata[7:0];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_LOW_COUNT)) begin
      st_d.low_count = avs_writedata[7:0];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_HIGH_RELOAD)) begin
      st_d.high_reload = avs_writedata[7:0];
    end
    if (wr && hit(avs_address, timer2_pkg::OFF_LOW_RELOAD)) begin
      st_d.low_reload = avs_writedata[7:0];
    end

    // Hardware sets win over a software clear in the same cycle
    if (ovf16 || hovf) begin
      st_d.overflow_flag = 1'b1;
    end
    if (trg_ev) begin
      st_d.external_flag = 1'b1;
    end
    if (lovf) begin
      st_d.low_overflow_flag = 1'b1;
    end

    // Shared interrupt request from the three flags
    st_d.irq = (st_q.overflow_flag && !st_q.overflow_irq_block)
               || st_q.external_flag
               || (st_q.low_overflow_flag && st_q.low_overflow_irq_enable);

    // Bus answer
    st_d.bus_wait = !take;
    if (take) begin
      st_d.rdata = read_reg(st_q, avs_address);
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q          <= '0;
      st_q.bus_wait <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = st_q.bus_wait;
  assign clock_out_pin   = st_q.clk_level;
  assign tx_baud_tick    = st_q.tx_tick;
  assign rx_baud_tick    = st_q.rx_tick;
  assign irq_request     = st_q.irq;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_tx_source;
    t2_event && st_q.tx_clock_select |=> tx_baud_tick;
  endproperty
  a_tx_source: assert property (p_tx_source) else $error("tx tick missing");

  property p_rx_source;
    !st_q.rx_clock_select && !timer1_overflow |=> !rx_baud_tick;
  endproperty
  a_rx_source: assert property (p_rx_source) else $error("rx tick from wrong source");
  property p_brg_reload;
    brg && ovf16 && !wr |=> cnt16 == $past({st_q.high_reload, st_q.low_reload});
  endproperty
  a_brg_reload: assert property (p_brg_reload) else $error("brg reload wrong");

  property p_ovf_flag;
    ovf16 |=> st_q.overflow_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");
  property p_brg_trigger;
    brg && trg_ev && !ovf16 && !wr && !hi_tick |=> st_q.external_flag && $stable(cnt16);
  endproperty
  a_brg_trigger: assert property (p_brg_trigger) else $error("brg trigger reloaded");

  property p_pwm_duty;
    pwm && hovf && !wr |=> st_q.low_count == $past(st_q.low_reload) && st_q.overflow_flag;
  endproperty
  a_pwm_duty: assert property (p_pwm_duty) else $error("pwm duty not loaded");
  property p_out_gated;
    !st_q.clock_out_enable |=> !clock_out_pin;
  endproperty
  a_out_gated: assert property (p_out_gated) else $error("clock out while disabled");

  property p_irq_block;
    st_q.overflow_irq_block && !st_q.external_flag && !st_q.low_overflow_flag |=> !irq_request;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("blocked request raised");
  property p_split_zero;
    pwm == 1'b0 && st_q.split_enable && mode == timer2_pkg::MODE_CAP_ZER && trg_ev && !wr
      |=> st_q.high_count == timer2_pkg::ZERO8;
  endproperty
  a_split_zero: assert property (p_split_zero) else $error("high count not zeroed");

  property p_toggle;
    clkout && !pwm && t2_event |=> clock_out_pin != $past(clock_out_pin);
  endproperty
  a_toggle: assert property (p_toggle) else $error("clock out did not toggle");
endmodule

// >>> hdl/timer2_pkg.sv
package timer2_pkg;

  // Register byte offsets on the slave bus
  localparam logic [4:0] OFF_CONTROL     = 5'h00;
  localparam logic [4:0] OFF_MODE        = 5'h04;
  localparam logic [4:0] OFF_MODE_EXT    = 5'h08;
  localparam logic [4:0] OFF_HIGH_COUNT  = 5'h0C;
  localparam logic [4:0] OFF_LOW_COUNT   = 5'h10;
  localparam logic [4:0] OFF_HIGH_RELOAD = 5'h14;
  localparam logic [4:0] OFF_LOW_RELOAD  = 5'h18;

  // Control register bit positions
  localparam int CON_OVF   = 7;
  localparam int CON_EXT   = 6;
  localparam int CON_VIEW5 = 5;
  localparam int CON_VIEW4 = 4;
  localparam int CON_FALL  = 3;
  localparam int CON_RUNH  = 2;
  localparam int CON_PIN   = 1;
  localparam int CON_CAPRL = 0;

  // Mode register bit positions
  localparam int MOD_SPLIT = 7;
  localparam int MOD_LFAST = 6;
  localparam int MOD_HFAST = 4;
  localparam int MOD_RUNL  = 3;
  localparam int MOD_OE    = 1;
  localparam int MOD_MS0   = 0;

  // Extended mode register bit positions
  localparam int MX_BLOCK = 6;
  localparam int MX_VIEW  = 5;
  localparam int MX_MS1   = 3;

  // Mode codes {ms1, capture_reload_select, ms0}
  localparam logic [2:0] MODE_AR_EXT  = 3'h0;
  localparam logic [2:0] MODE_AR_TRIG = 3'h1;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_CAP_ZER = 3'h3;
  localparam logic [2:0] MODE_PWM     = 3'h4;

  // Counter limits and reset values
  localparam logic [7:0]  MAX8      = 8'hFF;
  localparam logic [15:0] MAX16     = 16'hFFFF;
  localparam logic [7:0]  ZERO8     = 8'h00;
  localparam logic [7:0]  ONE8      = 8'h01;
  localparam logic [15:0] ONE16     = 16'h0001;
  localparam logic [31:0] RD_UNMAP  = 32'h0000_0000;
  localparam int          SYNC_LEN  = 3;

endpackage

// >>> verification/baud_partner.sv
`timescale 1ns/1ns
// Serial port side: supplies Timer 1 overflows and times the baud ticks
module baud_partner #(
  parameter int T1_PERIOD = 10
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Baud clocks from the timer
  input  wire logic        tx_baud_tick,
  input  wire logic        rx_baud_tick,
  // Timer 1 overflow pulse
  output logic             timer1_overflow,
  // Spacing of the last two ticks, in clocks
  output logic      [15:0] tx_gap,
  output logic      [15:0] rx_gap
);
  logic [15:0] t1_q;
  logic [15:0] tx_age_q;
  logic [15:0] rx_age_q;

  // Timer 1 stand-in, one pulse every T1_PERIOD clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      t1_q <= 16'h0000;
      timer1_overflow <= 1'b0;
    end else begin
      t1_q <= (t1_q == 16'(T1_PERIOD - 1)) ? 16'h0000 : t1_q + 16'h0001;
      timer1_overflow <= (t1_q == 16'(T1_PERIOD - 1));
    end
  end

  // Age counters; a lost or extra tick shows up as a wrong gap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_age_q <= 16'h0000;
      rx_age_q <= 16'h0000;
      tx_gap <= 16'h0000;
      rx_gap <= 16'h0000;
    end else begin
      tx_age_q <= tx_baud_tick ? 16'h0001 : tx_age_q + 16'h0001;
      rx_age_q <= rx_baud_tick ? 16'h0001 : rx_age_q + 16'h0001;
      if (tx_baud_tick) tx_gap <= tx_age_q;
      if (rx_baud_tick) rx_gap <= rx_age_q;
    end
  end
endmodule

// >>> verification/test_timer2_split_brg_clockout.sv
`timescale 1ns/1ns
module test_timer2_split_brg_clockout;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        trigger_input = 1'b1;
  logic        count_pin = 1'b1;
  logic        clock_out_pin;
  logic        timer1_overflow;
  logic        tx_baud_tick;
  logic        rx_baud_tick;
  logic        irq_request;
  logic [15:0] tx_gap;
  logic [15:0] rx_gap;
  logic [31:0] hi;
  int          num_errors = 0;
  int          tests_run = 0;
  // Control, mode and extended mode bit values
  localparam logic [7:0] OVF = 8'h01 << timer2_pkg::CON_OVF;
  localparam logic [7:0] EXT = 8'h01 << timer2_pkg::CON_EXT;
  localparam logic [7:0] B5 = 8'h01 << timer2_pkg::CON_VIEW5;
  localparam logic [7:0] B4 = 8'h01 << timer2_pkg::CON_VIEW4;
  localparam logic [7:0] FALL = 8'h01 << timer2_pkg::CON_FALL;
  localparam logic [7:0] RUNH = 8'h01 << timer2_pkg::CON_RUNH;
  localparam logic [7:0] SPL = 8'h01 << timer2_pkg::MOD_SPLIT;
  localparam logic [7:0] LF = 8'h01 << timer2_pkg::MOD_LFAST;
  localparam logic [7:0] HF = 8'h01 << timer2_pkg::MOD_HFAST;
  localparam logic [7:0] RUNL = 8'h01 << timer2_pkg::MOD_RUNL;
  localparam logic [7:0] OE = 8'h01 << timer2_pkg::MOD_OE;
  localparam logic [7:0] BLK = 8'h01 << timer2_pkg::MX_BLOCK;
  localparam logic [7:0] VIEW = 8'h01 << timer2_pkg::MX_VIEW;
  localparam logic [7:0] MS1 = 8'h01 << timer2_pkg::MX_MS1;
  localparam logic [7:0] MS0 = 8'h01 << timer2_pkg::MOD_MS0;
  localparam logic [7:0] PIN = 8'h01 << timer2_pkg::CON_PIN;
  localparam logic [7:0] CAP = 8'h01 << timer2_pkg::CON_CAPRL;

  // 50 MHz clock
  always #10 clk = ~clk;

  timer2_split_brg_clockout timer2_split_brg_clockout_inst (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_input_pin(count_pin),
    .trigger_input(trigger_input), .clock_out_pin(clock_out_pin),
    .timer1_overflow(timer1_overflow), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick), .irq_request(irq_request));

  baud_partner baud_partner_inst (
    .clk(clk), .sys_rst(sys_rst), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick), .timer1_overflow(timer1_overflow),
    .tx_gap(tx_gap), .rx_gap(rx_gap));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    // One wait cycle, so the answer is sampled at the second edge
    check("bus wait cycles", 32'd2, 32'(n));
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string name);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(name, e, q & m);
  endtask

  // Clocks of one high phase of clock_out_pin, from a low phase onward
  task automatic high_time(output logic [31:0] n);
    int w;
    w = 0;
    while (clock_out_pin !== 1'b0 && w < 600) begin @(posedge clk); w++; end
    while (clock_out_pin !== 1'b1 && w < 600) begin @(posedge clk); w++; end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (clock_out_pin === 1'b1 && n < 300);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung handshake or pin
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    results;
  end

  initial begin
    logic seen;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then an unmapped place that ignores writes
    for (int a = 0; a < 8; a++) rd(5'(a * 4), 32'hFFFF_FFFF, 32'h0000_0000, "reset value");
    wr(5'h1C, 8'hA5);
    rd(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    // 16-bit baud generator, reload FFF0: 16 counts at half clock
    wr(timer2_pkg::OFF_HIGH_RELOAD, 8'hFF);
    wr(timer2_pkg::OFF_LOW_RELOAD, 8'hF0);
    wr(timer2_pkg::OFF_HIGH_COUNT, 8'hFF);
    wr(timer2_pkg::OFF_LOW_COUNT, 8'hF0);
    wr(timer2_pkg::OFF_MODE_EXT, BLK);
    wr(timer2_pkg::OFF_CONTROL, B5 | RUNH);
    repeat (100) @(posedge clk);
    check("tx gap timer1", 32'd10, 32'(tx_gap));
    check("rx gap timer2", 32'd32, 32'(rx_gap));
    check("irq blocked", 32'h0000_0000, 32'(irq_request));
    rd(timer2_pkg::OFF_CONTROL, OVF, OVF, "brg overflow flag");
    wr(timer2_pkg::OFF_MODE_EXT, 8'h00);
    repeat (3) @(posedge clk);
    check("irq unblocked", 32'h0000_0001, 32'(irq_request));
    wr(timer2_pkg::OFF_CONTROL, B4 | RUNH | FALL);
    repeat (100) @(posedge clk);
    check("tx gap timer2", 32'd32, 32'(tx_gap));
    check("rx gap timer1", 32'd10, 32'(rx_gap));
    trigger_input <= 1'b0;
    repeat (80) @(posedge clk);
    rd(timer2_pkg::OFF_CONTROL, EXT, EXT, "trigger flag");
    check("gap after trigger", 32'd32, 32'(tx_gap));
    trigger_input <= 1'b1;
    wr(timer2_pkg::OFF_CONTROL, 8'h00);
    // Split PWM, period 16, duty F4 then F8
    wr(timer2_pkg::OFF_MODE, SPL | HF);
    wr(timer2_pkg::OFF_MODE_EXT, MS1);
    wr(timer2_pkg::OFF_HIGH_RELOAD, 8'hF0);
    wr(timer2_pkg::OFF_HIGH_COUNT, 8'hF0);
    wr(timer2_pkg::OFF_LOW_RELOAD, 8'hF4);
    wr(timer2_pkg::OFF_LOW_COUNT, 8'hF4);
    wr(timer2_pkg::OFF_CONTROL, RUNH);
    seen = 1'b0;
    repeat (40) begin @(posedge clk); seen = seen | (clock_out_pin !== 1'b0); end
    check("pwm gated off", 32'h0000_0000, 32'(seen));
    rd(timer2_pkg::OFF_CONTROL, OVF, OVF, "pwm overflow flag");
    wr(timer2_pkg::OFF_MODE, SPL | HF | OE);
    high_time(hi);
    check("pwm high time", 32'd4, hi);
    wr(timer2_pkg::OFF_LOW_RELOAD, 8'hF8);
    repeat (40) @(posedge clk);
    high_time(hi);
    check("pwm duty reload", 32'd8, hi);
    wr(timer2_pkg::OFF_CONTROL, 8'h00);
    wr(timer2_pkg::OFF_MODE, 8'h00);
    wr(timer2_pkg::OFF_MODE_EXT, 8'h00);
    // 16-bit clock-out at full clock, reload FFF0
    wr(timer2_pkg::OFF_HIGH_RELOAD, 8'hFF);
    wr(timer2_pkg::OFF_LOW_RELOAD, 8'hF0);
    wr(timer2_pkg::OFF_HIGH_COUNT, 8'hFF);
    wr(timer2_pkg::OFF_LOW_COUNT, 8'hF0);
    wr(timer2_pkg::OFF_MODE, HF | OE);
    check("clock-out starts low", 32'h0000_0000, 32'(clock_out_pin));
    wr(timer2_pkg::OFF_CONTROL, RUNH);
    high_time(hi);
    check("clock-out half period", 32'd16, hi);
    rd(timer2_pkg::OFF_CONTROL, OVF, OVF, "clock-out overflow flag");
    wr(timer2_pkg::OFF_CONTROL, 8'h00);
    wr(timer2_pkg::OFF_MODE, 8'h00);
    // Split clock-out from low_count, reload F8 at full clock
    wr(timer2_pkg::OFF_MODE_EXT, VIEW);
    // Timer stopped now, so this clear cannot meet an overflow
    wr(timer2_pkg::OFF_CONTROL, 8'h00);
    wr(timer2_pkg::OFF_HIGH_COUNT, 8'h55);
    wr(timer2_pkg::OFF_LOW_RELOAD, 8'hF8);
    wr(timer2_pkg::OFF_LOW_COUNT, 8'hF8);
    wr(timer2_pkg::OFF_MODE, SPL | LF);
    wr(timer2_pkg::OFF_MODE, SPL | LF | OE);
    wr(timer2_pkg::OFF_MODE, SPL | LF | OE | RUNL);
    high_time(hi);
    check("split clock-out half period", 32'd8, hi);
    rd(timer2_pkg::OFF_CONTROL, B5, B5, "low overflow flag");
    check("low irq masked", 32'h0000_0000, 32'(irq_request));
    wr(timer2_pkg::OFF_CONTROL, B4);
    repeat (20) @(posedge clk);
    check("low irq enabled", 32'h0000_0001, 32'(irq_request));
    rd(timer2_pkg::OFF_HIGH_COUNT, 32'hFFFF_FFFF, 32'h0000_0055, "high half idle");
    // Split capture with zeroing, then trigger reload, then pin counting
    wr(timer2_pkg::OFF_MODE, SPL | MS0);
    wr(timer2_pkg::OFF_CONTROL, FALL | CAP);
    trigger_input <= 1'b0;
    repeat (10) @(posedge clk);
    rd(timer2_pkg::OFF_HIGH_COUNT, 32'h0000_00FF, 32'h0000_0000, "split zero");
    rd(timer2_pkg::OFF_HIGH_RELOAD, 32'h0000_00FF, 32'h0000_0055, "split capture");
    wr(timer2_pkg::OFF_CONTROL, FALL);
    trigger_input <= 1'b1;
    repeat (10) @(posedge clk);
    trigger_input <= 1'b0;
    repeat (10) @(posedge clk);
    rd(timer2_pkg::OFF_HIGH_COUNT, 32'h0000_00FF, 32'h0000_0055, "split reload");
    wr(timer2_pkg::OFF_CONTROL, RUNH | PIN);
    // Each low phase outlasts the pin filter
    repeat (3) begin
      count_pin <= 1'b0;
      repeat (8) @(posedge clk);
      count_pin <= 1'b1;
      repeat (8) @(posedge clk);
    end
    rd(timer2_pkg::OFF_HIGH_COUNT, 32'h0000_00FF, 32'h0000_0058, "pin count");
    results;
  end
endmodule
